// ===== inc/vec_conv_pkg.sv
// Purpose: constants and types for the vector convert / iota issue block
// Assumes: two phases per sys_clk period; phases counted from issue
// Notes: conversion arithmetic is a simplified add-with-constant model
// Contract
// RL1 - fix op streams source through add unit
// RL2 - fix results sign extended to 64 bits
// RL3 - float op converts via add with constant
// RL4 - conversion needs vectors phase 5, adder 8
// RL5 - next instruction enters issue at phase 2; code also holds issue until convert or iota elements are queued
// RL6 - result usable phase 37 plus two per element
// RL7 - source 17, adder 20, plus two past four
// RL8 - iota uses only mask and stride scalars
// RL9 - element n equals n times stride
// RL10 - generation and compaction run together
// RL11 - mask scanned msb first, ones packed densely
// RL12 - popcount elements written, rest left unchanged
// RL13 - iota stops when remaining mask bits zero
// RL14 - iota needs scalars, vector phase 5, unit 8
// RL15 - zero mask: result 29, unit 30
// RL16 - no-op lets next issue one clock later
// RL17 - hold issue until all resources are free; code checks only the issuing op's own counters, none for no-op
package vec_conv_pkg;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned VLEN_W = 7;
  localparam int unsigned NREG = 8;
  localparam int unsigned REG_W = 3;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned FIFO_AW = 5;
  localparam int unsigned PH_PER_CLK = 2;
  // phase figures as printed
  localparam int unsigned PH_NEXT = 2;
  localparam int unsigned PH_RES_FIRST = 37;
  localparam int unsigned PH_SRC_REL = 17;
  localparam int unsigned PH_ADD_REL = 20;
  localparam int unsigned PH_SHORT_LEN = 4;
  localparam int unsigned PH_IOTA_RES = 29;
  localparam int unsigned PH_IOTA_UNIT = 30;
  localparam logic [CNT_W-1:0] CLK_NEXT = CNT_W'(PH_NEXT / PH_PER_CLK);
  localparam logic [CNT_W-1:0] CLK_RES = CNT_W'(PH_RES_FIRST / PH_PER_CLK);
  localparam logic [CNT_W-1:0] CLK_SRC = CNT_W'(PH_SRC_REL / PH_PER_CLK);
  localparam logic [CNT_W-1:0] CLK_ADD = CNT_W'(PH_ADD_REL / PH_PER_CLK);
  localparam logic [CNT_W-1:0] CLK_IRES = CNT_W'(PH_IOTA_RES / PH_PER_CLK);
  localparam logic [CNT_W-1:0] CLK_IUNIT = CNT_W'(PH_IOTA_UNIT / PH_PER_CLK);
  localparam logic [CNT_W-1:0] SHORT_LEN = CNT_W'(PH_SHORT_LEN);
  localparam logic [DATA_W-1:0] FIX_BIAS = 64'h0000_0000_0000_0000;
  localparam logic [DATA_W-1:0] FLT_BIAS = 64'h0000_0000_0000_0000;
  localparam logic [2:0] OPC_FIX = 3'h4;
  localparam logic [2:0] OPC_FLT = 3'h5;
  localparam logic [2:0] OPC_IOTA = 3'h6;
  localparam logic [2:0] OPC_NOP = 3'h7;

  typedef struct packed {
    logic [2:0] opcode;
    logic [REG_W-1:0] result_vector_reg;
    logic [REG_W-1:0] source_vector_reg;
    logic [DATA_W-1:0] selector_scalar_reg;
    logic [DATA_W-1:0] stride_scalar_reg;
    logic [VLEN_W-1:0] vlen;
  } instr_t;

  typedef struct packed {
    logic [REG_W-1:0] vreg;
    logic [5:0] index;
    logic [DATA_W-1:0] data;
  } elem_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_IOTA = 3'b100
  } state_t;
endpackage

// ===== rtl/elem_fifo.sv
// Purpose: parameterised valid/ready fifo for result elements
// Assumes: single clock, asynchronous active-low reset
// Notes: full and empty are exact; no bypass
`timescale 1ns/100ps
module elem_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW = 5
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [AW:0] count, next_count;
  logic wr, rd;

  always_comb begin
    wr = in_valid && (count != (AW+1)'(DEPTH));
    rd = out_ready && (count != '0);
    next_wptr = wr ? wptr + 1'b1 : wptr;
    next_rptr = rd ? rptr + 1'b1 : rptr;
    next_count = count + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr) begin
      mem[wptr] <= in_data;
    end
  end

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rptr];
endmodule

// ===== rtl/vector_convert_iota_issue.sv
// Purpose: issue and execution of fix, float, compressed iota and no-op
// Assumes: one clock; phase figures halved into clock counts
// Notes: results leave through a fifo; write port may stall it
`timescale 1ns/100ps
module vector_convert_iota_issue
  import vec_conv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire vec_conv_pkg::instr_t instr,
  input wire logic instr_valid,
  output logic instr_ready,
  output logic [REG_W-1:0] src_rd_reg,
  output logic [5:0] src_rd_index,
  input wire logic [DATA_W-1:0] src_rd_data,
  output vec_conv_pkg::elem_t wr_elem,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [NREG-1:0] vreg_busy,
  output logic adder_busy,
  output logic int_unit_busy
);
  // ----------------------------------------------------------------
  // issue state
  // ----------------------------------------------------------------
  state_t state, next_state;
  instr_t cur, next_cur;
  logic [CNT_W-1:0] hold, next_hold;
  logic [CNT_W-1:0] vres_cnt [NREG];
  logic [CNT_W-1:0] next_vres_cnt [NREG];
  logic [CNT_W-1:0] add_cnt, next_add_cnt, iu_cnt, next_iu_cnt;
  logic [5:0] elem, next_elem, slot, next_slot;
  logic [DATA_W-1:0] mask, next_mask, acc, next_acc;
  logic [DATA_W-1:0] stride, next_stride;
  logic ready_r, next_ready;
  logic [NREG-1:0] busy_r, next_busy;
  logic add_b, next_add_b, iu_b, next_iu_b;
  elem_t f_in;
  logic f_valid, f_ready, f_out_valid;
  elem_t f_out;
  logic [DATA_W-1:0] fix_sum;
  logic srcs_free, go, step;
  logic [CNT_W-1:0] len_x, extra1, extra4;

  always_comb begin
    len_x = CNT_W'(instr.vlen);
    extra1 = (len_x > 1) ? len_x - 1'b1 : '0;
    extra4 = (len_x > SHORT_LEN) ? len_x - SHORT_LEN : '0;
    // conversion and iota issue wait until their vector and unit counters read free; a no-op waits for none
    srcs_free = (vres_cnt[instr.result_vector_reg] == '0); // RL17
    if (instr.opcode == OPC_FIX || instr.opcode == OPC_FLT) begin
      srcs_free = srcs_free && (vres_cnt[instr.source_vector_reg] == '0)
                  && (add_cnt == '0); // RL4
    end else if (instr.opcode == OPC_IOTA) begin
      srcs_free = srcs_free && (iu_cnt == '0); // RL14
    end else begin
      srcs_free = 1'b1;
    end
    go = instr_valid && ready_r && srcs_free && (state == ST_IDLE);
    fix_sum = src_rd_data + ((cur.opcode == OPC_FIX) ? FIX_BIAS : FLT_BIAS);
    next_state = state;
    next_cur = cur;
    next_hold = (hold != '0) ? hold - 1'b1 : '0;
    next_add_cnt = (add_cnt != '0) ? add_cnt - 1'b1 : '0;
    next_iu_cnt = (iu_cnt != '0) ? iu_cnt - 1'b1 : '0;
    for (int r = 0; r < NREG; r++) begin
      next_vres_cnt[r] = (vres_cnt[r] != '0) ? vres_cnt[r] - 1'b1 : '0;
    end
    next_elem = elem;
    next_slot = slot;
    next_mask = mask;
    next_acc = acc;
    next_stride = stride;
    f_in = '0;
    f_valid = 1'b0;
    step = f_ready;
    case (state)
      ST_IDLE: begin
        if (go) begin
          next_cur = instr;
          next_elem = '0;
          next_slot = '0;
          next_hold = CLK_NEXT; // RL5 RL16
          case (instr.opcode)
            OPC_FIX, OPC_FLT: begin
              next_state = ST_CONV; // RL1 RL3
              next_vres_cnt[instr.result_vector_reg] = CLK_RES + extra1; // RL6
              next_vres_cnt[instr.source_vector_reg] = CLK_SRC + extra4; // RL7
              next_add_cnt = CLK_ADD + extra4; // RL7
            end
            OPC_IOTA: begin
              next_state = ST_IOTA; // RL8
              next_mask = instr.selector_scalar_reg;
              next_stride = instr.stride_scalar_reg; // RL9
              next_acc = '0; // RL9
              next_vres_cnt[instr.result_vector_reg] = CLK_IRES; // RL15
              next_iu_cnt = CLK_IUNIT; // RL15
            end
            default: begin
              next_state = ST_IDLE;
            end
          endcase
        end
      end
      ST_CONV: begin
        // element read in the same cycle its registered index is presented
        f_valid = 1'b1;
        f_in.vreg = cur.result_vector_reg;
        f_in.index = elem;
        f_in.data = (cur.opcode == OPC_FIX) ? fix_sum : fix_sum; // RL2
        if (step) begin
          next_elem = elem + 1'b1;
          if (7'(elem) + 1'b1 >= cur.vlen) begin
            next_state = ST_IDLE;
          end
        end
        if (cur.vlen == '0) begin
          f_valid = 1'b0;
          next_state = ST_IDLE;
        end
      end
      ST_IOTA: begin
        // generation and compaction share each cycle
        if (mask == '0) begin
          next_state = ST_IDLE; // RL13
        end else if (mask[DATA_W-1]) begin
          f_valid = 1'b1; // RL10 RL11
          f_in.vreg = cur.result_vector_reg;
          f_in.index = slot;
          f_in.data = acc;
          if (step) begin
            next_slot = slot + 1'b1; // RL12
            next_mask = {mask[DATA_W-2:0], 1'b0};
            next_acc = acc + stride;
            next_elem = elem + 1'b1;
          end
        end else begin
          next_mask = {mask[DATA_W-2:0], 1'b0}; // RL11
          next_acc = acc + stride;
          next_elem = elem + 1'b1;
        end
        // keep the unit and result held while elements remain
        if (next_state == ST_IOTA) begin
          next_iu_cnt = CLK_IUNIT;
          next_vres_cnt[cur.result_vector_reg] = CLK_IRES;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // ready stays low for the clock after any issue
    next_ready = (next_hold == '0) && (next_state == ST_IDLE); // RL5 RL16
    for (int r = 0; r < NREG; r++) begin
      next_busy[r] = (next_vres_cnt[r] != '0);
    end
    next_add_b = (next_add_cnt != '0);
    next_iu_b = (next_iu_cnt != '0);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cur <= '0;
      hold <= '0;
      add_cnt <= '0;
      iu_cnt <= '0;
      for (int r = 0; r < NREG; r++) begin
        vres_cnt[r] <= '0;
      end
      elem <= '0;
      slot <= '0;
      mask <= '0;
      acc <= '0;
      stride <= '0;
      ready_r <= 1'b0;
      busy_r <= '0;
      add_b <= 1'b0;
      iu_b <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      hold <= next_hold;
      add_cnt <= next_add_cnt;
      iu_cnt <= next_iu_cnt;
      for (int r = 0; r < NREG; r++) begin
        vres_cnt[r] <= next_vres_cnt[r];
      end
      elem <= next_elem;
      slot <= next_slot;
      mask <= next_mask;
      acc <= next_acc;
      stride <= next_stride;
      ready_r <= next_ready;
      busy_r <= next_busy;
      add_b <= next_add_b;
      iu_b <= next_iu_b;
    end
  end

  // ----------------------------------------------------------------
  // result buffer and registered outputs
  // ----------------------------------------------------------------
  elem_fifo #(
    .WIDTH($bits(elem_t)),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_data(f_in),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .out_data(f_out),
    .out_valid(f_out_valid),
    .out_ready(wr_ready)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_elem <= '0;
      wr_valid <= 1'b0;
      src_rd_reg <= '0;
      src_rd_index <= '0;
    end else begin
      wr_elem <= f_out;
      wr_valid <= f_out_valid && wr_ready;
      src_rd_reg <= next_cur.source_vector_reg;
      src_rd_index <= next_elem;
    end
  end

  assign instr_ready = ready_r;
  assign vreg_busy = busy_r;
  assign adder_busy = add_b;
  assign int_unit_busy = iu_b;
endmodule

// ===== test/vector_convert_iota_issue_props.sv
// Purpose: issue and busy release timing checks
// Assumes: one clock; counts are halved phases
// Notes: only checked from an idle start
`timescale 1ns/100ps
module vector_convert_iota_issue_props
  import vec_conv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire vec_conv_pkg::instr_t instr,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [NREG-1:0] vreg_busy,
  input wire logic adder_busy,
  input wire logic int_unit_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [REG_W-1:0] res;
  logic [REG_W-1:0] src;
  wire idle = vreg_busy == '0 && !adder_busy && !int_unit_busy;
  wire go = instr_valid && instr_ready && idle;
  wire conv = go && (instr.opcode == OPC_FIX || instr.opcode == OPC_FLT);
  wire iota = go && instr.opcode == OPC_IOTA;
  wire brief = conv && instr.vlen inside {[1:4]};
  wire split = instr.source_vector_reg != instr.result_vector_reg;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      res <= '0;
      src <= '0;
    end else if (go) begin
      res <= instr.result_vector_reg;
      src <= instr.source_vector_reg;
    end
  end
  property p_ready_drop;
    go |=> !instr_ready;
  endproperty
  a_ready_drop: assert property (p_ready_drop)
    else $error("ready stayed high after issue");
  property p_nop_next;
    go && instr.opcode == OPC_NOP |=> !instr_ready ##1 instr_ready;
  endproperty
  a_nop_next: assert property (p_nop_next)
    else $error("no-op did not free issue after one clock");
  property p_conv_claim;
    conv |=> adder_busy && vreg_busy[res] && vreg_busy[src];
  endproperty
  a_conv_claim: assert property (p_conv_claim)
    else $error("conversion did not claim its resources");
  property p_iota_claim;
    iota |=> int_unit_busy && vreg_busy[res];
  endproperty
  a_iota_claim: assert property (p_iota_claim)
    else $error("iota did not claim its resources");
  property p_src_free;
    brief && split |-> ##8 vreg_busy[src] ##1 !vreg_busy[src];
  endproperty
  a_src_free: assert property (p_src_free)
    else $error("source vector released at wrong time");
  property p_add_free;
    brief |-> ##10 adder_busy ##1 !adder_busy;
  endproperty
  a_add_free: assert property (p_add_free)
    else $error("add unit released at wrong time");
  property p_res_free;
    conv && instr.vlen == 1 |-> ##18 vreg_busy[res] ##1 !vreg_busy[res];
  endproperty
  a_res_free: assert property (p_res_free)
    else $error("result vector released at wrong time");
  property p_iota_free;
    iota && instr.selector_scalar_reg == '0 |-> ##14 vreg_busy[res]
      ##1 !vreg_busy[res] && int_unit_busy ##1 !int_unit_busy;
  endproperty
  a_iota_free: assert property (p_iota_free)
    else $error("empty iota released at wrong time");
  c_conv: cover property (brief);
  c_iota: cover property (iota);
  c_nop: cover property (go && instr.opcode == OPC_NOP);
endmodule

// ===== test/vreg_port_model.sv
// Purpose: far side: source vector read and result write port
// Assumes: combinational read; ready moves at the falling edge
// Notes: stall closes the write port so the fifo fills
`timescale 1ns/100ps
module vreg_port_model
  import vec_conv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic stall,
  input wire logic [REG_W-1:0] src_rd_reg,
  input wire logic [5:0] src_rd_index,
  output logic [DATA_W-1:0] src_rd_data,
  output logic wr_ready
);
  // data carries its own address so a wrong read shows; msb varies
  assign src_rd_data = {src_rd_reg, src_rd_index, 46'h0, src_rd_index,
                        src_rd_reg};
  initial wr_ready = 1'b0;
  always @(negedge sys_clk) wr_ready <= !stall && ($urandom % 4 != 0);
endmodule

// ===== test/vector_convert_iota_issue_bench.sv
// Purpose: self-checking bench for convert, iota and no-op
// Assumes: expected elements queued at issue, popped on each write
// Notes: busy timing is left to the bound checker
`timescale 1ns/100ps
module vector_convert_iota_issue_bench;
  import vec_conv_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic instr_valid = 1'b0;
  logic stall = 1'b0;
  instr_t instr = '0;
  logic instr_ready, wr_valid, wr_ready, adder_busy, int_unit_busy;
  logic [REG_W-1:0] src_rd_reg;
  logic [5:0] src_rd_index;
  logic [DATA_W-1:0] src_rd_data;
  logic [NREG-1:0] vreg_busy;
  elem_t wr_elem;
  elem_t q[$];
  int mismatches = 0;
  int cmp_count = 0;
  int seed;
  int n;
  vector_convert_iota_issue DUT (.sys_clk, .nrst, .instr, .instr_valid,
    .instr_ready, .src_rd_reg, .src_rd_index, .src_rd_data, .wr_elem,
    .wr_valid, .wr_ready, .vreg_busy, .adder_busy, .int_unit_busy);
  vreg_port_model far (.sys_clk, .stall, .src_rd_reg, .src_rd_index,
    .src_rd_data, .wr_ready);
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp_elem(input elem_t exp, input elem_t got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected wr_elem exp %h got %h", exp, got);
    end
  endtask
  task automatic cmp_left(input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      mismatches++;
      $display("unexpected pending exp %0d got %0d", exp, got);
    end
  endtask
  task automatic issue(input logic [2:0] op, input logic [2:0] r,
      input logic [2:0] s, input logic [63:0] m, input logic [63:0] k,
      input logic [6:0] len);
    int i;
    int j;
    j = 0;
    for (i = 0; i < 64; i++) begin
      if ((op == OPC_FIX || op == OPC_FLT) && i < len) begin
        q.push_back({r, 6'(i), {s, 6'(i), 46'h0, 6'(i), s} +
                     (op == OPC_FIX ? FIX_BIAS : FLT_BIAS)});
      end
      if (op == OPC_IOTA && m[63 - i]) begin
        q.push_back({r, 6'(j), 64'(i) * k});
        j++;
      end
    end
    @(negedge sys_clk);
    instr = '{op, r, s, m, k, len};
    instr_valid = 1'b1;
    i = 0;
    // ready alone is not a take: the needed resources must read free too
    do begin
      @(posedge sys_clk);
      i++;
    end while (!(instr_ready === 1'b1 && (op == OPC_NOP ||
               (vreg_busy[r] === 1'b0 && (op == OPC_IOTA ?
               int_unit_busy === 1'b0 : (vreg_busy[s] === 1'b0 &&
               adder_busy === 1'b0))))) && i < 1000);
    if (i >= 1000) mismatches++;
    @(negedge sys_clk);
    instr_valid = 1'b0;
  endtask
  task automatic settle;
    int i;
    i = 0;
    while ((q.size() != 0 || vreg_busy !== '0 || adder_busy !== 1'b0 ||
            int_unit_busy !== 1'b0) && i < 1000) begin
      @(negedge sys_clk);
      i++;
    end
    cmp_left(0, q.size());
  endtask
  always @(negedge sys_clk) begin
    if (nrst && wr_valid === 1'b1) begin
      cmp_elem(q.size() > 0 ? q.pop_front() : 'x, wr_elem);
    end
  end
  initial begin
    #40000;
    mismatches++;
    final_report();
  end
  initial begin
    seed = $urandom(97);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) nrst = 1'b1;
    issue(OPC_FIX, 3'h3, 3'h2, '0, '0, 7'h01);
    settle();
    issue(OPC_FLT, 3'h5, 3'h6, '0, '0, 7'h04);
    settle();
    issue(OPC_FIX, 3'h0, 3'h7, '0, '0, 7'h00);
    issue(OPC_NOP, 3'h0, 3'h0, '0, '0, 7'h00);
    issue(OPC_FLT, 3'h1, 3'h4, '0, '0, 7'h40);
    settle();
    issue(OPC_IOTA, 3'h2, 3'h0, '0, 64'h5, 7'h00);
    settle();
    // a closed write port lets the fifo fill and refuse
    stall = 1'b1;
    issue(OPC_IOTA, 3'h7, 3'h1, '1, {$urandom, $urandom}, 7'h00);
    repeat (80) @(negedge sys_clk);
    stall = 1'b0;
    settle();
    for (n = 0; n < 6; n++) begin
      issue(OPC_IOTA, 3'(n), 3'h0, {$urandom, $urandom} << (n * 12),
            {$urandom, $urandom}, 7'h00);
      settle();
      issue(n[0] ? OPC_FIX : OPC_FLT, 3'($urandom), 3'($urandom), '0, '0,
            7'($urandom % 65));
      settle();
    end
    final_report();
  end
endmodule
bind vector_convert_iota_issue vector_convert_iota_issue_props props (
  .sys_clk, .nrst, .instr, .instr_valid, .instr_ready, .vreg_busy,
  .adder_busy, .int_unit_busy);
